// ==== hw/fmst_core.sv ====
// fmst_core: memory control, deflection, blanking, clock division and 4:1:1 data paths
//
// Contract
// - make store controls on acquisition timing and fetch controls on display timing
// - store gate is horizontal window from line sync and vertical from field sync
// - fetch gate is horizontal window from line sync and vertical from field sync
// - each field sync rise gives a 64 us store pointer clear pulse
// - second memory input gate is a static host level
// - line deflection drive repeats every 32 us, 76 display cycles wide
// - frame deflection cycles every 10 ms, start and stop in 16 us steps
// - line blank pulse start and stop count from display line sync rise
// - host writes every start and stop value
// - a video line is 2048 cycles of the line locked clock
// - acquisition clock is display clock divided by two
// - line reference is acquisition clock divided by 1024, half duty
// - measure delay from line sync rise to line reference as phase error
// - select input picks external acquisition clock; sync must follow it
// - display line sync has half duty; its rise is the display reference
// - acquisition clock goes out as the memory serial clock
// - four phases: luma per phase, u then v bit pairs high first
// - first phase leaves one serial clock after the store gate rises
// - incoming first phase expected at the programmable input fetch start
// - luma straight binary, u and v two's complement on both buses
// - chroma input invert set inverts received u and v
// - chroma input invert is bit 3 of control byte 3F
`timescale 1ns/1ps
module fmst_core #(
  parameter int CLEAR_CYC = fmst_pkg::CLEAR_CYC
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // clock and sync pins
  input  wire logic                  display_clock,
  input  wire logic                  acquisition_clock,
  input  wire logic                  acq_clock_source_select,
  input  wire logic                  acq_line_sync,
  input  wire logic                  field_sync_in,
  // host timing set
  input  wire logic                  cfg_wr,
  input  wire fmst_pkg::fmst_cfg_s   cfg,
  // pixel words to and from the core
  input  wire fmst_pkg::fmst_px_s    px_in,
  output fmst_pkg::fmst_px_s         px_out,
  output logic                       px_out_valid,
  output logic                       px_taken,
  // field memory buses
  input  wire logic [7:0]            mem_yi,
  input  wire logic [3:0]            mem_uvi,
  output logic [7:0]                 mem_yo,
  output logic [3:0]                 mem_uvo,
  output logic                       memory_serial_clock,
  // memory controls
  output logic                       store_gate,
  output logic                       store_pointer_clear,
  output logic                       field_fetch_gate,
  output logic                       second_memory_input_gate,
  // deflection, blanking and references
  output logic                       line_deflection_drive,
  output logic                       frame_deflection_drive,
  output logic                       line_blank_pulse,
  output logic                       display_line_sync,
  output logic                       line_ref,
  output logic [fmst_pkg::RW-1:0]    phase_error
);

  localparam int CW = $clog2(CLEAR_CYC + 1);
  localparam int SW = $clog2(fmst_pkg::STEP_DISP);

  // two flop synchroniser; stage three only feeds edge detection
  fmst_pkg::fmst_pin_s pin_raw, s1_q, s2_q, s3_q;
  assign pin_raw = {display_clock, acquisition_clock, acq_clock_source_select,
                    acq_line_sync, field_sync_in, mem_yi, mem_uvi};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // clock enables and sync edges
  logic acq_tog_q;
  wire  disp_en    = s2_q.dclk & ~s3_q.dclk;
  wire  ext_acq_en = s2_q.xclk & ~s3_q.xclk;
  wire  int_acq_en = disp_en & ~acq_tog_q;
  wire  acq_en     = s2_q.sel ? ext_acq_en : int_acq_en;
  wire  hs_rise    = s2_q.hsync & ~s3_q.hsync;
  wire  vs_rise    = s2_q.vsync & ~s3_q.vsync;

  // host timing set latch; arming releases the gates, deflection drives, blanking and pointer clear
  fmst_pkg::fmst_cfg_s cfg_q;
  logic                armed_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= '0;
      armed_q <= 1'b0;
    end else if (cfg_wr) begin
      cfg_q   <= cfg;
      armed_q <= 1'b1;
    end
  end

  // position counters
  logic [fmst_pkg::RW-1:0] href_cnt_q;
  logic [fmst_pkg::HW-1:0] acq_hpos_q, fetch_hpos_q;
  logic [fmst_pkg::VW-1:0] line_cnt_q, step_cnt_q;
  logic [fmst_pkg::DW-1:0] disp_hpos_q;
  wire step_tick = disp_en && (disp_hpos_q[SW-1:0] == SW'(fmst_pkg::STEP_DISP - 1));
  wire step_wrap = step_cnt_q == fmst_pkg::VW'(fmst_pkg::FRAME_STEPS - 1);

  // acquisition side counts and the free running display line count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_tog_q    <= 1'b0;
      href_cnt_q   <= '0;
      acq_hpos_q   <= '0;
      fetch_hpos_q <= '0;
      line_cnt_q   <= '0;
      disp_hpos_q  <= '0;
    end else begin
      if (disp_en) acq_tog_q <= ~acq_tog_q;
      if (acq_en) href_cnt_q <= href_cnt_q + 1'b1;
      if (hs_rise) acq_hpos_q <= '0;
      else if (acq_en) acq_hpos_q <= acq_hpos_q + 1'b1;
      if (hs_rise) fetch_hpos_q <= '0;
      else if (disp_en) fetch_hpos_q <= fetch_hpos_q + 1'b1;
      if (vs_rise) line_cnt_q <= '0;
      else if (hs_rise) line_cnt_q <= line_cnt_q + 1'b1;
      if (disp_en) disp_hpos_q <= disp_hpos_q + 1'b1;   // wraps every 32 us
    end
  end

  // 16 us step count, restarted by field sync and wrapped at 10 ms
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_q <= '0;
    end else if (vs_rise) begin
      step_cnt_q <= '0;
    end else if (step_tick) begin
      step_cnt_q <= step_wrap ? '0 : step_cnt_q + 1'b1;
    end
  end

  // line reference and phase error; the error is the count since the
  // reference rise, so a sync that lands on the rise reads zero
  logic                    line_ref_q;
  logic [fmst_pkg::RW-1:0] phase_error_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ref_q    <= 1'b0;
      phase_error_q <= '0;
    end else begin
      line_ref_q <= href_cnt_q[fmst_pkg::RW-1];
      if (hs_rise) phase_error_q <= href_cnt_q - fmst_pkg::HREF_HALF;
    end
  end
  assign line_ref    = line_ref_q;
  assign phase_error = phase_error_q;

  // window compares for the composite gates, frame drive and blanking
  logic st_h, st_v, fe_h, fe_v;
  fmst_win #(.W(fmst_pkg::HW)) u_store_h (.clk(core_clk), .rst_n(rst_n), .arm(armed_q),
    .start(cfg_q.store_h_start), .stop(cfg_q.store_h_stop), .pos(acq_hpos_q), .hit_q(st_h));
  fmst_win #(.W(fmst_pkg::VW)) u_store_v (.clk(core_clk), .rst_n(rst_n), .arm(armed_q),
    .start(cfg_q.store_v_start), .stop(cfg_q.store_v_stop), .pos(line_cnt_q), .hit_q(st_v));
  fmst_win #(.W(fmst_pkg::HW)) u_fetch_h (.clk(core_clk), .rst_n(rst_n), .arm(armed_q),
    .start(cfg_q.fetch_h_start), .stop(cfg_q.fetch_h_stop), .pos(fetch_hpos_q), .hit_q(fe_h));
  fmst_win #(.W(fmst_pkg::VW)) u_fetch_v (.clk(core_clk), .rst_n(rst_n), .arm(armed_q),
    .start(cfg_q.fetch_v_start), .stop(cfg_q.fetch_v_stop), .pos(line_cnt_q), .hit_q(fe_v));
  fmst_win #(.W(fmst_pkg::VW)) u_frame (.clk(core_clk), .rst_n(rst_n), .arm(armed_q),
    .start(cfg_q.frame_start), .stop(cfg_q.frame_stop), .pos(step_cnt_q),
    .hit_q(frame_deflection_drive));
  fmst_win #(.W(fmst_pkg::DW)) u_blank (.clk(core_clk), .rst_n(rst_n), .arm(armed_q),
    .start(cfg_q.blank_start), .stop(cfg_q.blank_stop), .pos(disp_hpos_q),
    .hit_q(line_blank_pulse));

  // store pointer clear length counter, retriggered by each field sync
  logic [CW-1:0] clr_cnt_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt_q <= '0;
    end else if (vs_rise) begin
      clr_cnt_q <= CW'(CLEAR_CYC);
    end else if (clr_cnt_q != '0) begin
      clr_cnt_q <= clr_cnt_q - 1'b1;
    end
  end

  // registered control outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_gate               <= 1'b0;
      field_fetch_gate         <= 1'b0;
      store_pointer_clear      <= 1'b0;
      second_memory_input_gate <= 1'b0;
      line_deflection_drive    <= 1'b0;
      display_line_sync        <= 1'b0;
      memory_serial_clock      <= 1'b0;
    end else begin
      store_gate               <= st_h & st_v;
      field_fetch_gate         <= fe_h & fe_v;
      store_pointer_clear      <= armed_q && (vs_rise || clr_cnt_q > CW'(1));
      second_memory_input_gate <= armed_q & cfg_q.second_gate;
      line_deflection_drive    <= armed_q && (disp_hpos_q < fmst_pkg::DW'(fmst_pkg::DEFL_PULSE));
      display_line_sync        <= ~disp_hpos_q[fmst_pkg::DW-1];
      memory_serial_clock      <= s2_q.sel ? s2_q.xclk : acq_tog_q;
    end
  end

  // outgoing word: detect the gate rise on one serial edge, start on the next
  logic       gate_seen_q, go_q, run_q;
  logic [1:0] oph_q;
  fmst_pkg::fmst_px_s word_q;
  wire        st_rise = store_gate & ~gate_seen_q;
  wire        drive   = go_q | (run_q & (oph_q != 2'd0 | store_gate));
  wire [1:0]  ph      = go_q ? 2'd0 : oph_q;
  wire fmst_pkg::fmst_px_s src = (ph == 2'd0) ? px_in : word_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_seen_q <= 1'b0;
      go_q        <= 1'b0;
      run_q       <= 1'b0;
      oph_q       <= '0;
      word_q      <= '0;
      mem_yo      <= '0;
      mem_uvo     <= '0;
      px_taken    <= 1'b0;
    end else begin
      px_taken <= 1'b0;
      if (acq_en) begin
        gate_seen_q <= store_gate;
        go_q        <= st_rise;
        if (drive) begin
          if (ph == 2'd0) begin
            word_q   <= px_in;
            px_taken <= 1'b1;
          end
          mem_yo  <= src.y[ph];
          mem_uvo <= {src.u[{~ph, 1'b1}], src.u[{~ph, 1'b0}],
                      src.v[{~ph, 1'b1}], src.v[{~ph, 1'b0}]};
          oph_q   <= ph + 2'd1;
          run_q   <= 1'b1;
        end else begin
          run_q <= 1'b0;
          oph_q <= '0;
        end
      end
    end
  end

  // incoming word: phases gathered from the input fetch start to line end
  logic       in_run_q;
  logic [1:0] iph_q;
  fmst_pkg::fmst_px_s in_q, in_nx;
  wire in_start = armed_q && (acq_hpos_q == cfg_q.in_fetch_start);
  wire in_take  = acq_en && (in_start || in_run_q);
  wire [1:0] iph = in_start ? 2'd0 : iph_q;

  // current phase merged into the partial word
  always_comb begin
    in_nx                   = in_q;
    in_nx.y[iph]            = s2_q.yi;
    in_nx.u[{~iph, 1'b1}]   = s2_q.uvi[3];
    in_nx.u[{~iph, 1'b0}]   = s2_q.uvi[2];
    in_nx.v[{~iph, 1'b1}]   = s2_q.uvi[1];
    in_nx.v[{~iph, 1'b0}]   = s2_q.uvi[0];
  end

  // invert is bitwise, so a chroma value of -128 still has an image
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_run_q     <= 1'b0;
      iph_q        <= '0;
      in_q         <= '0;
      px_out       <= '0;
      px_out_valid <= 1'b0;
    end else begin
      px_out_valid <= 1'b0;
      if (hs_rise) begin
        in_run_q <= 1'b0;
        iph_q    <= '0;
      end else if (in_take) begin
        in_run_q <= 1'b1;
        in_q     <= in_nx;
        iph_q    <= iph + 2'd1;
        if (iph == 2'd3) begin
          px_out_valid <= 1'b1;
          px_out.y     <= in_nx.y;
          px_out.u     <= cfg_q.chroma_input_invert ? ~in_nx.u : in_nx.u;
          px_out.v     <= cfg_q.chroma_input_invert ? ~in_nx.v : in_nx.v;
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [CW:0] clr_hi_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) clr_hi_q <= '0;
    else clr_hi_q <= store_pointer_clear ? clr_hi_q + 1'b1 : '0;
  end

  chk_clear_width: assert property ($fell(store_pointer_clear) && !$past(vs_rise, 2)
    |-> clr_hi_q == (CW + 1)'(CLEAR_CYC)) else $error("pointer clear width wrong");
  chk_defl_width: assert property ($past(armed_q) && $past(disp_hpos_q) == 10'h04B
    |-> line_deflection_drive) else $error("line drive ended early");
  chk_defl_end: assert property ($past(disp_hpos_q) == 10'h04C
    |-> !line_deflection_drive) else $error("line drive too long");
  chk_hsync_rise: assert property ($rose(display_line_sync)
    |-> $past(disp_hpos_q) == '0) else $error("display line sync rise misplaced");
  chk_lineref_rise: assert property ($rose(line_ref)
    |-> $past(href_cnt_q, 2) == 10'h1FF) else $error("line reference rise misplaced");
  chk_serial_clock: assert property (!s2_q.sel && int_acq_en ##1 !s2_q.sel
    |=> memory_serial_clock) else $error("serial clock not following acquisition");
  chk_gate2_level: assert property (##1 second_memory_input_gate
    == $past(armed_q & cfg_q.second_gate)) else $error("second gate not the host level");
  chk_quiet_unarmed: assert property (!armed_q && !$past(armed_q, 2) |-> !store_gate
    && !field_fetch_gate && !frame_deflection_drive && !line_blank_pulse
    && !line_deflection_drive && !store_pointer_clear) else $error("output before arming");
  chk_first_phase: assert property (go_q && acq_en
    |=> mem_yo == $past(px_in.y[0]) && px_taken) else $error("first phase not sent");

  cov_store_word: cover property (go_q && acq_en ##[1:40] px_taken);
  cov_in_word: cover property (px_out_valid && cfg_q.chroma_input_invert);
  cov_clear_pulse: cover property ($fell(store_pointer_clear));

endmodule

// ==== hw/fmst_pkg.sv ====
// fmst_pkg: constants and carrier types for the field memory sync timing block
package fmst_pkg;

  // core clock rate and the documented time figures in their own units
  localparam int CORE_MHZ     = 250;
  localparam int DISP_MHZ     = 32;
  localparam int LINE_DEFL_US = 32;
  localparam int STEP_US      = 16;
  localparam int FRAME_MS     = 10;
  localparam int CLEAR_US     = 64;

  // derived counts
  localparam int DISP_LINE    = LINE_DEFL_US * DISP_MHZ;     // display cycles per 32 us line
  localparam int STEP_DISP    = STEP_US * DISP_MHZ;          // display cycles per 16 us step
  localparam int FRAME_STEPS  = FRAME_MS * 1000 / STEP_US;   // steps per 10 ms frame cycle
  localparam int CLEAR_CYC    = CLEAR_US * CORE_MHZ;         // core cycles of pointer clear
  localparam int DEFL_PULSE   = 76;                          // line drive width, display cycles
  localparam int LINE_LOCK    = 2048;                        // 32 MHz cycles per video line
  localparam int HREF_DIV     = 1024;                        // acquisition cycles per line
  localparam int WORD_PHASES  = 4;

  // widths
  localparam int HW = $clog2(LINE_LOCK);   // horizontal position width
  localparam int VW = 10;                  // line and step count width
  localparam int RW = $clog2(HREF_DIV);    // line reference divider width
  localparam int DW = $clog2(DISP_LINE);   // display position width

  // host written timing set, latched on a write strobe
  typedef struct packed {
    logic [HW-1:0] store_h_start;
    logic [HW-1:0] store_h_stop;
    logic [VW-1:0] store_v_start;
    logic [VW-1:0] store_v_stop;
    logic [HW-1:0] fetch_h_start;
    logic [HW-1:0] fetch_h_stop;
    logic [VW-1:0] fetch_v_start;
    logic [VW-1:0] fetch_v_stop;
    logic [VW-1:0] frame_start;
    logic [VW-1:0] frame_stop;
    logic [DW-1:0] blank_start;
    logic [DW-1:0] blank_stop;
    logic [HW-1:0] in_fetch_start;
    logic          second_gate;
    logic          chroma_input_invert;
  } fmst_cfg_s;

  // one 4:1:1 word: four luma samples, one u and one v
  typedef struct packed {
    logic [3:0][7:0] y;
    logic [7:0]      u;
    logic [7:0]      v;
  } fmst_px_s;

  // asynchronous pins passed through the synchroniser together
  typedef struct packed {
    logic       dclk;
    logic       xclk;
    logic       sel;
    logic       hsync;
    logic       vsync;
    logic [7:0] yi;
    logic [3:0] uvi;
  } fmst_pin_s;

  localparam logic [RW-1:0] HREF_HALF = RW'(HREF_DIV / 2);

endpackage

// ==== hw/fmst_win.sv ====
// fmst_win: registered start/stop window compare on a position count
`timescale 1ns/1ps
module fmst_win #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // window setting
  input  wire logic         arm,
  input  wire logic [W-1:0] start,
  input  wire logic [W-1:0] stop,
  input  wire logic [W-1:0] pos,
  // result
  output logic              hit_q
);

  // set at start, clear at stop; an empty window when stop is not past start
  wire in_win = (pos >= start) && (pos < stop);

  // held low until the host has armed the block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= arm && in_win;
    end
  end

endmodule

// ==== dv/fmst_mem_model.sv ====
// fmst_mem_model: clocks, syncs and read bus of the memory and sync side
`timescale 1ns/1ps
module fmst_mem_model (
  // control from the bench
  input  wire logic       field_go,
  // clock and sync pins
  output logic            display_clock,
  output logic            acquisition_clock,
  output logic            acq_line_sync,
  output logic            field_sync_in,
  // memory read bus
  output logic [7:0]      mem_yi,
  output logic [3:0]      mem_uvi
);
  logic [10:0] line_cnt = 11'h000;

  // 32 ns stands in for 31.25 ns so one display cycle is exactly 8 core cycles
  initial display_clock = 1'b0;
  always #16 display_clock = ~display_clock;

  // free running external acquisition clock, 48 ns, unrelated to the core
  initial acquisition_clock = 1'b0;
  always #24 acquisition_clock = ~acquisition_clock;

  // line sync every 2048 display cycles; field sync follows the bench request
  always @(posedge display_clock) begin
    line_cnt <= line_cnt + 11'h001;
    acq_line_sync <= (line_cnt < 11'h080);
    field_sync_in <= field_go;
  end

  // constant word: luma 3c straight binary, u pairs 01 and v pairs 10
  assign mem_yi  = 8'h3C;
  assign mem_uvi = 4'h6;
endmodule

// ==== dv/tb.sv ====
// tb: self-checking bench for the field memory sync timing core
`timescale 1ns/1ps
module tb;
  // clock, reset and host side
  logic                core_clk = 1'b0;
  logic                rst_n    = 1'b0;
  logic                cfg_wr   = 1'b0;
  logic                sel      = 1'b0;
  logic                field_go = 1'b0;
  fmst_pkg::fmst_cfg_s cfg      = '0;
  fmst_pkg::fmst_px_s  px_in    = '0;
  // pins of the memory side
  wire logic           dclk, xclk, hs, vs;
  wire logic [7:0]     yi;
  wire logic [3:0]     uvi;
  // design outputs
  fmst_pkg::fmst_px_s  px_out;
  logic                pv, pt, msc, sg, spc, ffg, smg, ldd, fdd, lbp, dls, lref;
  logic [7:0]          yo;
  logic [3:0]          uvo;
  logic [9:0]          perr;
  wire logic [8:0]     obs = {fdd, spc, msc, lref, ffg, sg, lbp, dls, ldd};
  int                  n_mismatch  = 0;
  int                  check_count = 0;
  int                  cyc         = 0;

  always #2 core_clk = ~core_clk;

  fmst_mem_model mem_u (.field_go(field_go), .display_clock(dclk), .acquisition_clock(xclk),
    .acq_line_sync(hs), .field_sync_in(vs), .mem_yi(yi), .mem_uvi(uvi));

  fmst_core #(.CLEAR_CYC(20)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .display_clock(dclk), .acquisition_clock(xclk), .acq_clock_source_select(sel),
    .acq_line_sync(hs), .field_sync_in(vs), .cfg_wr(cfg_wr), .cfg(cfg), .px_in(px_in),
    .px_out(px_out), .px_out_valid(pv), .px_taken(pt), .mem_yi(yi), .mem_uvi(uvi),
    .mem_yo(yo), .mem_uvo(uvo), .memory_serial_clock(msc), .store_gate(sg),
    .store_pointer_clear(spc), .field_fetch_gate(ffg), .second_memory_input_gate(smg),
    .line_deflection_drive(ldd), .frame_deflection_drive(fdd), .line_blank_pulse(lbp),
    .display_line_sync(dls), .line_ref(lref), .phase_error(perr));

  // hang guard: the full sequence needs about 65k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // inputs change 1 ns after the edge, outputs are read there too
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr();
    cfg_wr = 1'b1;
    tick();
    cfg_wr = 1'b0;
  endtask

  // high time and optional period of one observed output, in core cycles
  task automatic width(input int i, input int hi, input int per);
    int n;
    int m;
    for (n = 0; n < 40000 && obs[i] !== 1'b0; n++) tick();
    for (n = 0; n < 40000 && obs[i] !== 1'b1; n++) tick();
    for (n = 0; n < 40000 && obs[i] === 1'b1; n++) tick();
    for (m = 0; per > 0 && m < 40000 && obs[i] !== 1'b1; m++) tick();
    chk(n, hi);
    if (per > 0) chk(n + m, per);
  endtask

  // no gate, drive, blank or clear before the first timing write, serial clock runs
  task automatic t_idle();
    int  act;
    int  tog;
    logic last;
    act = 0;
    tog = 0;
    last = msc;
    repeat (300) begin
      tick();
      if ({ldd, fdd, lbp, sg, ffg, spc, smg} !== 7'h00) act++;
      if (msc !== last) tog++;
      last = msc;
    end
    chk(act, 0);
    chk(tog > 0, 1);
  endtask

  // full timing set written at once; second gate follows the host level
  task automatic t_gate();
    cfg.store_h_start = 11'h00A;
    cfg.store_h_stop  = 11'h190;
    cfg.store_v_stop  = 10'h3E8;
    cfg.fetch_h_start = 11'h032;
    cfg.fetch_h_stop  = 11'h0FA;
    cfg.fetch_v_stop  = 10'h3E8;
    cfg.frame_start   = 10'h001;
    cfg.frame_stop    = 10'h003;
    cfg.blank_start   = 10'h064;
    cfg.blank_stop    = 10'h12C;
    cfg.in_fetch_start = 11'h014;
    cfg.second_gate   = 1'b1;
    wr();
    repeat (3) tick();
    chk(smg, 1'b1);
    cfg.second_gate = 1'b0;
    wr();
    repeat (3) tick();
    chk(smg, 1'b0);
  endtask

  // every periodic window but the frame drive measured side by side to save run time
  task automatic t_windows();
    fork
      width(0, 608, 8192);
      width(1, 4096, 8192);
      width(2, 1600, 8192);
      width(3, 6240, 16384);
      width(4, 1600, 16384);
      width(5, 8192, 16384);
      width(6, 8, 16);
    join
  endtask

  // field sync rise: pointer clear and frame drive steps from it
  task automatic t_field();
    field_go = 1'b1;
    fork
      width(7, 20, 0);
      width(8, 8192, 0);
    join
    field_go = 1'b0;
  endtask

  // outgoing word phases, luma per phase and chroma pairs high first
  task automatic t_data_out();
    int n;
    int p;
    px_in.y = {8'h44, 8'h33, 8'h22, 8'h11};
    px_in.u = 8'hE4;
    px_in.v = 8'h1B;
    // let one edge pass so the word seen was latched after px_in changed
    tick();
    for (n = 0; n < 20000 && pt !== 1'b1; n++) tick();
    chk(sg, 1'b1);
    for (p = 0; p < 4; p++) begin
      for (n = 0; p > 0 && n < 40 && yo === px_in.y[p-1]; n++) tick();
      chk({yo, uvo}, {px_in.y[p], px_in.u[7-2*p -: 2], px_in.v[7-2*p -: 2]});
    end
  endtask

  // incoming word with the chroma invert off and on; first word skipped
  task automatic t_data_in();
    int n;
    int k;
    int inv;
    for (inv = 0; inv < 2; inv++) begin
      cfg.chroma_input_invert = inv[0];
      wr();
      for (k = 0; k < 2; k++) begin
        tick();
        for (n = 0; n < 20000 && pv !== 1'b1; n++) tick();
      end
      if (inv == 0) chk(px_out, {{4{8'h3C}}, 8'h55, 8'hAA});
      else chk(px_out, {{4{8'h3C}}, 8'hAA, 8'h55});
    end
  endtask

  // line sync period matches the reference, so the error holds still
  task automatic t_phase();
    logic [9:0] pe;
    pe = perr;
    repeat (16400) tick();
    chk(perr, pe);
  endtask

  // external acquisition clock: serial clock follows its 48 ns period
  task automatic t_ext_clk();
    sel = 1'b1;
    repeat (20) tick();
    width(6, 6, 12);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_idle();
    t_gate();
    t_windows();
    t_field();
    t_data_out();
    t_data_in();
    t_phase();
    t_ext_clk();
    complete_run();
  end
endmodule
